// ---- cise_pkg.sv ----
// Constants, opcode patterns and decoded-instruction carrier for the executor.
// Assumes 14-bit instruction words and 8-bit data.
package cise_pkg;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int INSTR_W = 14;
  localparam int PC_W = 13;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int FILE_DEPTH = 128;
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  localparam logic [DATA_W-1:0] W_RST = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DEST_BIT = 7;
  localparam int BR_K_W = 11;
  localparam int LATCH_HI = 4;
  localparam int LATCH_LO = 3;

  // ----------------------------------------------------------------
  // Opcode matching: value under mask
  // ----------------------------------------------------------------
  localparam logic [INSTR_W-1:0] CLR_MASK = 14'h3f80;
  localparam logic [INSTR_W-1:0] CLR_VAL = 14'h0100;
  localparam logic [INSTR_W-1:0] FOP_MASK = 14'h3f00;
  localparam logic [INSTR_W-1:0] DECSZ_VAL = 14'h0b00;
  localparam logic [INSTR_W-1:0] INCSZ_VAL = 14'h0f00;
  localparam logic [INSTR_W-1:0] INC_VAL = 14'h0a00;
  localparam logic [INSTR_W-1:0] BR_MASK = 14'h3800;
  localparam logic [INSTR_W-1:0] BR_VAL = 14'h2800;
  localparam logic [INSTR_W-1:0] IOR_MASK = 14'h3f00;
  localparam logic [INSTR_W-1:0] IOR_VAL = 14'h3800;

  typedef enum logic [2:0] {
    CISE_OP_NOP,
    CISE_OP_ACC_CLEAR,
    CISE_OP_DEC_SKIP,
    CISE_OP_INC_SKIP,
    CISE_OP_FILE_INC,
    CISE_OP_BRANCH,
    CISE_OP_LIT_OR
  } cise_op_e;

  typedef struct packed {
    cise_op_e op;
    logic dest_file;
    logic [FADDR_W-1:0] faddr;
    logic [DATA_W-1:0] lit8;
    logic [BR_K_W-1:0] lit11;
  } cise_dec_s;

endpackage

// ---- cise_exec.sv ----
// Executor for a subset of an 8-bit core's instruction set, with its own file registers.
// Assumes the instruction word for pc_r is presented in the same instruction clock.
// How it works
// - Clearing the accumulator writes zero to it and always sets the zero flag.
// - File arithmetic writes the accumulator when the destination bit is 0, else file f.
// - Decrement-and-skip stores f-1, flushes the next instruction on zero, keeps flags.
// - Increment-and-skip stores f+1, flushes the next instruction on zero, keeps flags.
// - The branch loads its 11-bit literal into pc 10:0 and latch bits 4:3 into pc 12:11.
// - Literal-OR puts accumulator OR literal into the accumulator and updates zero.
// - Plain increment stores f+1 at the destination, updates zero and never skips.
`timescale 1ns/1ns
module cise_exec #(
  parameter int DEPTH = cise_pkg::FILE_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Instruction stream
  input wire logic [cise_pkg::INSTR_W-1:0] instr,
  input wire logic [cise_pkg::DATA_W-1:0] pc_high_latch,
  // Core state
  output logic [cise_pkg::PC_W-1:0] pc_r,
  output logic [cise_pkg::DATA_W-1:0] w_r,
  output logic zero_r,
  output logic flush_r,
  // File write observation
  output logic file_we_r,
  output logic [cise_pkg::FADDR_W-1:0] file_addr_r,
  output logic [cise_pkg::DATA_W-1:0] file_wdata_r
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  cise_pkg::cise_dec_s dec;
  logic [cise_pkg::DATA_W-1:0] mem_r [DEPTH];
  logic [cise_pkg::DATA_W-1:0] fval;
  logic [cise_pkg::DATA_W-1:0] res;
  logic exec;
  logic file_op;
  logic to_w;
  logic to_f;
  logic skip_nxt;
  logic z_upd;

  always_comb begin
    dec.op = cise_pkg::CISE_OP_NOP;
    dec.dest_file = instr[cise_pkg::DEST_BIT];
    dec.faddr = instr[cise_pkg::FADDR_W-1:0];
    dec.lit8 = instr[cise_pkg::DATA_W-1:0];
    dec.lit11 = instr[cise_pkg::BR_K_W-1:0];
    if ((instr & cise_pkg::CLR_MASK) == cise_pkg::CLR_VAL) begin
      dec.op = cise_pkg::CISE_OP_ACC_CLEAR;
    end else if ((instr & cise_pkg::FOP_MASK) == cise_pkg::DECSZ_VAL) begin
      dec.op = cise_pkg::CISE_OP_DEC_SKIP;
    end else if ((instr & cise_pkg::FOP_MASK) == cise_pkg::INCSZ_VAL) begin
      dec.op = cise_pkg::CISE_OP_INC_SKIP;
    end else if ((instr & cise_pkg::FOP_MASK) == cise_pkg::INC_VAL) begin
      dec.op = cise_pkg::CISE_OP_FILE_INC;
    end else if ((instr & cise_pkg::BR_MASK) == cise_pkg::BR_VAL) begin
      dec.op = cise_pkg::CISE_OP_BRANCH;
    end else if ((instr & cise_pkg::IOR_MASK) == cise_pkg::IOR_VAL) begin
      dec.op = cise_pkg::CISE_OP_LIT_OR;
    end
  end

  // ----------------------------------------------------------------
  // Execute
  // ----------------------------------------------------------------
  // A flushed slot executes as a no-operation whatever word is presented.
  assign exec = !flush_r;
  assign fval = mem_r[dec.faddr];
  assign file_op = (dec.op == cise_pkg::CISE_OP_DEC_SKIP) ||
                   (dec.op == cise_pkg::CISE_OP_INC_SKIP) ||
                   (dec.op == cise_pkg::CISE_OP_FILE_INC);

  always_comb begin
    res = cise_pkg::ZERO_BYTE;
    z_upd = 1'b0;
    unique case (dec.op)
      cise_pkg::CISE_OP_ACC_CLEAR: begin
        res = cise_pkg::ZERO_BYTE;
        z_upd = 1'b1;
      end
      cise_pkg::CISE_OP_DEC_SKIP: res = fval - cise_pkg::ONE_BYTE;
      cise_pkg::CISE_OP_INC_SKIP: res = fval + cise_pkg::ONE_BYTE;
      cise_pkg::CISE_OP_FILE_INC: begin
        res = fval + cise_pkg::ONE_BYTE;
        z_upd = 1'b1;
      end
      cise_pkg::CISE_OP_LIT_OR: begin
        res = w_r | dec.lit8;
        z_upd = 1'b1;
      end
      cise_pkg::CISE_OP_BRANCH: res = cise_pkg::ZERO_BYTE;
      cise_pkg::CISE_OP_NOP: res = cise_pkg::ZERO_BYTE;
    endcase
  end

  assign to_w = exec && ((dec.op == cise_pkg::CISE_OP_ACC_CLEAR) ||
                (dec.op == cise_pkg::CISE_OP_LIT_OR) || (file_op && !dec.dest_file));
  assign to_f = exec && file_op && dec.dest_file;
  assign skip_nxt = exec && (((dec.op == cise_pkg::CISE_OP_DEC_SKIP) ||
                    (dec.op == cise_pkg::CISE_OP_INC_SKIP)) && (res == cise_pkg::ZERO_BYTE) ||
                    (dec.op == cise_pkg::CISE_OP_BRANCH));

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pc_r <= cise_pkg::PC_RST;
    end else if (exec && dec.op == cise_pkg::CISE_OP_BRANCH) begin
      pc_r <= {pc_high_latch[cise_pkg::LATCH_HI:cise_pkg::LATCH_LO], dec.lit11};
    end else begin
      pc_r <= pc_r + 13'h0001;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flush_r <= 1'b0;
    end else begin
      flush_r <= skip_nxt;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      w_r <= cise_pkg::W_RST;
    end else if (to_w) begin
      w_r <= res;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      zero_r <= 1'b0;
    end else if (exec && z_upd) begin
      // Clear yields a zero result, so the same compare always sets the flag.
      zero_r <= (res == cise_pkg::ZERO_BYTE);
    end
  end

  // File registers reset to zero so a test can predict every read.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= cise_pkg::ZERO_BYTE;
      end
    end else if (to_f) begin
      mem_r[dec.faddr] <= res;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      file_we_r <= 1'b0;
      file_addr_r <= '0;
      file_wdata_r <= cise_pkg::ZERO_BYTE;
    end else begin
      file_we_r <= to_f;
      file_addr_r <= dec.faddr;
      file_wdata_r <= res;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_CLEAR: assert property (@(posedge mclk) disable iff (!arst_n)
    exec && dec.op == cise_pkg::CISE_OP_ACC_CLEAR |=> w_r == 8'h00 && zero_r)
    else $error("accumulator clear wrong");
  AST_DEST_W: assert property (@(posedge mclk) disable iff (!arst_n)
    exec && file_op && !dec.dest_file |=> w_r == $past(res) && !file_we_r)
    else $error("file result missed accumulator");
  AST_DEST_F: assert property (@(posedge mclk) disable iff (!arst_n)
    exec && file_op && dec.dest_file |=> file_we_r && $stable(w_r))
    else $error("file result missed file");
  AST_DEC_SKIP: assert property (@(posedge mclk) disable iff (!arst_n)
    exec && dec.op == cise_pkg::CISE_OP_DEC_SKIP |=>
    flush_r == ($past(fval) == 8'h01) && $stable(zero_r))
    else $error("decrement skip wrong");
  AST_INC_SKIP: assert property (@(posedge mclk) disable iff (!arst_n)
    exec && dec.op == cise_pkg::CISE_OP_INC_SKIP |=>
    flush_r == ($past(fval) == 8'hff) && $stable(zero_r))
    else $error("increment skip wrong");
  AST_BRANCH: assert property (@(posedge mclk) disable iff (!arst_n)
    exec && dec.op == cise_pkg::CISE_OP_BRANCH |=>
    flush_r && pc_r == {$past(pc_high_latch[4:3]), $past(instr[10:0])} ##1 !flush_r)
    else $error("branch target wrong");
  AST_LIT_OR: assert property (@(posedge mclk) disable iff (!arst_n)
    exec && dec.op == cise_pkg::CISE_OP_LIT_OR |=>
    w_r == ($past(w_r) | $past(instr[7:0])) && zero_r == (w_r == 8'h00))
    else $error("literal or wrong");
  AST_INC: assert property (@(posedge mclk) disable iff (!arst_n)
    exec && dec.op == cise_pkg::CISE_OP_FILE_INC |=>
    !flush_r && zero_r == ($past(fval) == 8'hff))
    else $error("plain increment wrong");
  // The flag is judged from the value that was stored, not from the internal result bus.
  AST_ZERO: assert property (@(posedge mclk) disable iff (!arst_n)
    exec && z_upd && dec.op != cise_pkg::CISE_OP_ACC_CLEAR |=>
    zero_r == ((file_we_r ? file_wdata_r : w_r) == 8'h00))
    else $error("zero flag wrong");
  // A flushed slot must leave the accumulator, zero flag and file registers alone and must not flush again.
  AST_FLUSH_NOP: assert property (@(posedge mclk) disable iff (!arst_n)
    flush_r |=> $stable(w_r) && $stable(zero_r) && !file_we_r && !flush_r)
    else $error("flushed slot changed state");
  AST_PC_STEP: assert property (@(posedge mclk) disable iff (!arst_n)
    !(exec && dec.op == cise_pkg::CISE_OP_BRANCH) |=> pc_r == $past(pc_r) + 13'h0001)
    else $error("pc did not step by one");

  CV_SKIP: cover property (@(posedge mclk) disable iff (!arst_n)
    exec && dec.op == cise_pkg::CISE_OP_DEC_SKIP ##1 flush_r);
  CV_BRANCH: cover property (@(posedge mclk) disable iff (!arst_n)
    exec && dec.op == cise_pkg::CISE_OP_BRANCH);
  CV_INC_WRAP: cover property (@(posedge mclk) disable iff (!arst_n)
    exec && dec.op == cise_pkg::CISE_OP_FILE_INC ##1 zero_r);
  CV_INC_SKIP: cover property (@(posedge mclk) disable iff (!arst_n)
    exec && dec.op == cise_pkg::CISE_OP_INC_SKIP ##1 flush_r);

endmodule // cise_exec

// ---- tb_cise_exec.sv ----
// Self-checking testbench for the instruction-subset executor.
// Assumes the executor keeps its own file registers and shows writes on its file_* ports.
`timescale 1ns/1ns
module tb_cise_exec;
  // ----------------------------------------------------------------
  // Signals and reference state
  // ----------------------------------------------------------------
  logic mclk;
  logic arst_n;
  logic [13:0] instr;
  logic [7:0] pc_high_latch;
  logic [12:0] pc_r;
  logic [7:0] w_r;
  logic zero_r;
  logic flush_r;
  logic file_we_r;
  logic [6:0] file_addr_r;
  logic [7:0] file_wdata_r;
  int fail_count;
  int checks;
  int seed_ret;
  logic [7:0] mem [128];
  logic [7:0] m_w, m_d;
  logic m_z, m_fl, m_we;
  logic [6:0] m_a;
  logic [12:0] m_pc;
  logic [13:0] dir [13] = '{14'h0a85, 14'h0b85, 14'h3800, 14'h0b86, 14'h0f86, 14'h0f06,
    14'h0100, 14'h3800, 14'h38a5, 14'h2fff, 14'h0a7f, 14'h0a7f, 14'h0000};

  cise_exec i_cise_exec (.mclk(mclk), .arst_n(arst_n), .instr(instr),
    .pc_high_latch(pc_high_latch), .pc_r(pc_r), .w_r(w_r), .zero_r(zero_r),
    .flush_r(flush_r), .file_we_r(file_we_r), .file_addr_r(file_addr_r),
    .file_wdata_r(file_wdata_r));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Compare tasks and reference model
  // ----------------------------------------------------------------
  task automatic cmp1(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp13(input logic [12:0] got, input logic [12:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic model_reset();
    m_pc = 13'h0000;
    m_w = 8'h00;
    m_z = 1'b0;
    m_fl = 1'b0;
    m_we = 1'b0;
    m_a = 7'h00;
    m_d = 8'h00;
    foreach (mem[k]) mem[k] = 8'h00;
  endtask

  // A flushed slot still advances the pc, so the skip costs exactly one extra cycle.
  task automatic step(input logic [13:0] i, input logic [7:0] lat);
    logic [7:0] r;
    logic [6:0] f;
    f = i[6:0];
    m_we = 1'b0;
    m_pc = m_pc + 13'h0001;
    if (m_fl) begin
      m_fl = 1'b0;
      return;
    end
    case (i[13:8])
      6'h01: begin
        if (!i[7]) begin
          m_w = 8'h00;
          m_z = 1'b1;
        end
      end
      6'h0a, 6'h0b, 6'h0f: begin
        r = (i[13:8] == 6'h0b) ? mem[f] - 8'h01 : mem[f] + 8'h01;
        if (i[7]) begin
          mem[f] = r;
          m_we = 1'b1;
          m_a = f;
          m_d = r;
        end else begin
          m_w = r;
        end
        if (i[13:8] == 6'h0a) begin
          m_z = (r == 8'h00);
        end else begin
          m_fl = (r == 8'h00);
        end
      end
      6'h38: begin
        m_w = m_w | i[7:0];
        m_z = (m_w == 8'h00);
      end
      default: begin
        if (i[13:11] == 3'b101) begin
          m_pc = {lat[4:3], i[10:0]};
          m_fl = 1'b1;
        end
      end
    endcase
  endtask

  function automatic logic [13:0] rnd_instr();
    logic [6:0] f;
    logic [13:0] d;
    f = ($urandom % 2) ? 7'($urandom % 4) : 7'h7f - 7'($urandom % 2);
    d = 14'($urandom % 2) << 7;
    case ($urandom % 7)
      0: return 14'h0100 | 14'($urandom % 128);
      1: return 14'h0b00 | d | 14'(f);
      2: return 14'h0f00 | d | 14'(f);
      3: return 14'h0a00 | d | 14'(f);
      4: return 14'h2800 | 14'($urandom % 2048);
      5: return 14'h3800 | 14'($urandom % 256);
      default: return 14'h0000;
    endcase
  endfunction

  task automatic check_all();
    cmp13(pc_r, m_pc, "pc");
    cmp8(w_r, m_w, "accumulator");
    cmp1(zero_r, m_z, "zero flag");
    cmp1(flush_r, m_fl, "skip slot");
    cmp1(file_we_r, m_we, "file write");
    if (m_we) begin
      cmp8({1'b0, file_addr_r}, {1'b0, m_a}, "file address");
      cmp8(file_wdata_r, m_d, "file data");
    end
  endtask

  // Called at a falling edge: check settled outputs, then drive the next word.
  task automatic run(input logic [13:0] i, input logic [7:0] lat);
    check_all();
    instr = i;
    pc_high_latch = lat;
    step(i, lat);
    @(negedge mclk);
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    instr = 14'h0000;
    pc_high_latch = 8'h00;
    fail_count = 0;
    checks = 0;
    seed_ret = $urandom(32'ha36f);
    model_reset();
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    arst_n = 1'b1;
    foreach (dir[k]) run(dir[k], 8'h18);
    repeat (1000) run(rnd_instr(), 8'($urandom));
    // The last word before a reset would otherwise go unchecked.
    check_all();
    arst_n = 1'b0;
    model_reset();
    @(negedge mclk);
    arst_n = 1'b1;
    repeat (500) run(rnd_instr(), 8'($urandom));
    check_all();
    tally_and_finish();
  end

  initial begin
    #(40 * 3000);
    fail_count++;
    tally_and_finish();
  end
endmodule // tb_cise_exec
